// ==== bol_map.svh ====
`ifndef BOL_MAP_SVH
`define BOL_MAP_SVH
`define BOL_STRAP_W        26
`define BOL_ADDR_LATCHED   12'h000
`define BOL_ADDR_DECODED   12'h004
`define BOL_ADDR_STATUS    12'h008
`define BOL_ADDR_DEBUG     12'h00c
`define BOL_BIT_BOOT_LO    0
`define BOL_BIT_TDM        3
`define BOL_BIT_RSVD4      4
`define BOL_BIT_AUX        5
`define BOL_BIT_XTAL       6
`define BOL_BIT_RANGE      7
`define BOL_BIT_REF_LO     8
`define BOL_BIT_L2SYNC     10
`define BOL_BIT_LANE1      11
`define BOL_BIT_LANE2      12
`define BOL_BIT_MAC3       13
`define BOL_BIT_DMDRV      14
`define BOL_BIT_TRACE      15
`define BOL_BIT_BAUD       16
`define BOL_BIT_SECURE     17
`define BOL_BIT_ALEN_LO    18
`define BOL_BIT_POL        20
`define BOL_BIT_PLL        21
`define BOL_REF_XTAL       2'b11
`define BOL_BAUD_SLOW      20'd115200
`define BOL_BAUD_FAST      20'd921600
`define BOL_BLK_BASE_KB    12'h020
`define BOL_BLK_SMALL_KB   12'h010
`define BOL_BLK_MAX_SEL    3'h6
`define BOL_BLK_SMALL_THR  3'h2
`define BOL_RESP_OKAY      2'b00
`define BOL_RESP_SLVERR    2'b10
`endif

// ==== bol_pkg.sv ====
package bol_pkg;
	typedef enum logic [2:0] {
		bol_boot_spi_slow = 3'h0,
		bol_boot_i2c      = 3'h1,
		bol_boot_spi_fast = 3'h2,
		bol_boot_uart     = 3'h3,
		bol_boot_rsvd     = 3'h4,
		bol_boot_sata     = 3'h5,
		bol_boot_nor8     = 3'h6,
		bol_boot_nor16    = 3'h7
	} bol_boot_t;
	typedef enum logic [1:0] {
		bol_in_reset = 2'b00,
		bol_capture  = 2'b01,
		bol_run      = 2'b11
	} bol_phase_t;
endpackage : bol_pkg

// ==== bol_latch.sv ====
// The AXI4-Lite register port and the address map were left to the implementer.
`include "bol_map.svh"
module bol_latch
	import bol_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// Strap / address pins
	input  wire logic [`BOL_STRAP_W-1:0] strap_address_pins_in,
	output logic      [`BOL_STRAP_W-1:0] strap_address_pins_out,
	output logic      [`BOL_STRAP_W-1:0] strap_address_pins_oe,
	// Expansion bus core side
	input  wire logic [`BOL_STRAP_W-1:0] exp_addr,
	input  wire logic                   exp_write_cycle,
	output logic                        expansion_data_bus_oe,
	// Trace and telephony clock pins
	output logic                        trace_pins_oe,
	output logic                        tdm_clk_oe,
	// Decoded configuration
	input  wire logic                   debug_mode_en,
	output logic                        third_mac_port_telephony,
	output logic                        second_serial_lane_sgmii,
	output logic                        first_serial_lane_sata,
	output logic                        level2_cache_ctrl_sync,
	output logic                        lane_osc_pads_sel,
	output logic                        osc_range_select_n,
	output logic                        osc_range_aux,
	output logic                        crystal_mode_strap,
	output logic                        ref_strap_bad,
	output bol_boot_t                   boot_source_select,
	output logic                        boot_source_bad,
	output logic [19:0]                 uart_baud,
	output logic                        secure_boot_en,
	output logic [2:0]                  spi_addr_bytes,
	output logic                        spi_addr_bad,
	output logic [11:0]                 id_block_kb,
	input  wire logic                   page_512,
	output logic                        spi_clk_pos,
	output logic                        pll_en,
	output logic                        config_valid,
	// AXI4-Lite slave
	input  wire logic [11:0]            s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [11:0]            s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	logic [`BOL_STRAP_W-1:0] pin_meta;
	logic [`BOL_STRAP_W-1:0] pin_sync;
	logic [`BOL_STRAP_W-1:0] latched_strap_value;
	bol_phase_t              phase;
	logic                    aw_held;
	logic                    w_held;
	logic [11:0]             aw_addr;
	logic [31:0]             decoded_word;
	logic [31:0]             status_word;

	// Pins are asynchronous to clk while pulled; two stages before use
	// No reset here: the stages must track the pulls during reset
	always_ff @(posedge clk) begin
		pin_meta <= strap_address_pins_in;
		pin_sync <= pin_meta;
	end

	// Synchroniser needs two edges to flush before the capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= bol_in_reset;
		end else begin
			case (phase)
				bol_in_reset: phase <= bol_capture;
				bol_capture:  phase <= bol_run;
				default:      phase <= bol_run;
			endcase
		end
	end

	// Single-cycle capture; pins stay released until it is done
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			latched_strap_value <= '0;
		end else if (phase == bol_capture) begin
			latched_strap_value <= pin_sync;
		end
	end

	assign config_valid = (phase == bol_run);

	// Undriven in reset and until capture, then expansion address
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_address_pins_oe  <= '0;
			strap_address_pins_out <= '0;
		end else begin
			strap_address_pins_oe  <= {`BOL_STRAP_W{phase == bol_run}};
			strap_address_pins_out <= exp_addr;
		end
	end

	// Hardware option decode
	always_comb begin
		trace_pins_oe            = config_valid && !latched_strap_value[`BOL_BIT_TRACE];
		expansion_data_bus_oe    = config_valid &&
		                           (latched_strap_value[`BOL_BIT_DMDRV] || exp_write_cycle);
		third_mac_port_telephony = latched_strap_value[`BOL_BIT_MAC3];
		second_serial_lane_sgmii = latched_strap_value[`BOL_BIT_LANE2];
		first_serial_lane_sata   = latched_strap_value[`BOL_BIT_LANE1];
		level2_cache_ctrl_sync   = latched_strap_value[`BOL_BIT_L2SYNC];
		lane_osc_pads_sel        = latched_strap_value[`BOL_BIT_REF_LO +: 2] == `BOL_REF_XTAL;
		// Flag only; the board owns the legal value
		ref_strap_bad            = config_valid && !lane_osc_pads_sel;
		osc_range_select_n       = latched_strap_value[`BOL_BIT_RANGE];
		osc_range_aux            = 1'b1;
		crystal_mode_strap       = latched_strap_value[`BOL_BIT_XTAL];
		tdm_clk_oe               = config_valid && latched_strap_value[`BOL_BIT_TDM];
		boot_source_select       = bol_boot_t'(latched_strap_value[`BOL_BIT_BOOT_LO +: 3]);
		boot_source_bad          = boot_source_select == bol_boot_rsvd;
	end

	// Software option decode
	always_comb begin
		uart_baud      = latched_strap_value[`BOL_BIT_BAUD] ? `BOL_BAUD_FAST : `BOL_BAUD_SLOW;
		secure_boot_en = debug_mode_en && latched_strap_value[`BOL_BIT_SECURE];
		spi_addr_bytes = 3'h0;
		spi_addr_bad   = 1'b0;
		case (latched_strap_value[`BOL_BIT_ALEN_LO +: 2])
			2'b01:   spi_addr_bytes = 3'h2;
			2'b10:   spi_addr_bytes = 3'h3;
			2'b11:   spi_addr_bytes = 3'h4;
			default: spi_addr_bytes = 3'h0;
		endcase
		// Fast SPI only handles three-byte devices
		if (boot_source_select == bol_boot_spi_fast) begin
			spi_addr_bad = spi_addr_bytes != 3'h3;
		end else if (boot_source_select == bol_boot_spi_slow) begin
			spi_addr_bad = spi_addr_bytes == 3'h0;
		end
		if (page_512 && latched_strap_value[`BOL_BIT_SECURE +: 3] > `BOL_BLK_SMALL_THR) begin
			id_block_kb = `BOL_BLK_SMALL_KB;
		end else if (latched_strap_value[`BOL_BIT_SECURE +: 3] >= `BOL_BLK_MAX_SEL) begin
			id_block_kb = `BOL_BLK_BASE_KB << `BOL_BLK_MAX_SEL;
		end else begin
			id_block_kb = `BOL_BLK_BASE_KB << latched_strap_value[`BOL_BIT_SECURE +: 3];
		end
		spi_clk_pos = latched_strap_value[`BOL_BIT_POL];
		pll_en      = latched_strap_value[`BOL_BIT_PLL];
	end

	always_comb begin
		decoded_word = '0;
		decoded_word[2:0]   = boot_source_select;
		decoded_word[6:4]   = spi_addr_bytes;
		decoded_word[19:8]  = id_block_kb;
		decoded_word[20]    = secure_boot_en;
		status_word = '0;
		status_word[0] = config_valid;
		status_word[1] = ref_strap_bad;
		status_word[2] = boot_source_bad;
		status_word[3] = spi_addr_bad;
		// Bit 5 should equal bit 7; report a mismatch
		status_word[4] = latched_strap_value[`BOL_BIT_AUX] != latched_strap_value[`BOL_BIT_RANGE];
	end

	// Write channel: accept address and data in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
			end
		end
	end

	// All registers are read-only; writes change nothing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `BOL_RESP_OKAY;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == `BOL_ADDR_LATCHED || aw_addr == `BOL_ADDR_DECODED ||
			                 aw_addr == `BOL_ADDR_STATUS) ? `BOL_RESP_OKAY : `BOL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `BOL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `BOL_RESP_OKAY;
			if (s_axi_araddr == `BOL_ADDR_LATCHED) begin
				s_axi_rdata <= {6'h00, latched_strap_value};
			end else if (s_axi_araddr == `BOL_ADDR_DECODED) begin
				s_axi_rdata <= decoded_word;
			end else if (s_axi_araddr == `BOL_ADDR_STATUS) begin
				s_axi_rdata <= status_word;
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= `BOL_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : bol_latch

// ==== bol_latch_props.sv ====
`include "bol_map.svh"
module bol_latch_props
	import bol_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Pins
	input wire logic [25:0] strap_address_pins_out,
	input wire logic [25:0] strap_address_pins_oe,
	input wire logic [25:0] exp_addr,
	// Configuration
	input wire logic        exp_write_cycle,
	input wire logic        expansion_data_bus_oe,
	input wire logic        trace_pins_oe,
	input wire logic        third_mac_port_telephony,
	input wire bol_boot_t   boot_source_select,
	input wire logic        lane_osc_pads_sel,
	input wire logic        ref_strap_bad,
	input wire logic        debug_mode_en,
	input wire logic        secure_boot_en,
	input wire logic [19:0] uart_baud,
	input wire logic        config_valid,
	// Read address and data
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_oe_idle: assert property (!config_valid |-> strap_address_pins_oe == 26'h0)
		else $error("pins driven before capture");
	a_pins_drive: assert property (config_valid && $past(config_valid) |->
		strap_address_pins_oe == 26'h3ffffff) else $error("pins not driven");
	a_addr_follow: assert property (strap_address_pins_oe[0] |=>
		strap_address_pins_out == $past(exp_addr)) else $error("address not driven");
	a_cfg_hold: assert property (config_valid && $past(config_valid) |->
		$stable({trace_pins_oe, third_mac_port_telephony, boot_source_select}))
		else $error("configuration changed");
	a_dm_write: assert property (config_valid && exp_write_cycle |->
		expansion_data_bus_oe) else $error("data bus idle on write");
	a_baud_legal: assert property (config_valid |->
		uart_baud == `BOL_BAUD_SLOW || uart_baud == `BOL_BAUD_FAST) else $error("bad baud");
	a_secure_gate: assert property (!debug_mode_en |-> !secure_boot_en)
		else $error("secure boot without debug");
	a_ref_flag: assert property (config_valid |-> ref_strap_bad == !lane_osc_pads_sel)
		else $error("reference flag wrong");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
endmodule : bol_latch_props

bind bol_latch bol_latch_props u_props (.*);

// ==== bol_board.sv ====
module bol_board (
	// Strap pulls
	input  wire logic [25:0] pulls,
	// Pad side
	input  wire logic [25:0] oe,
	input  wire logic [25:0] out,
	output logic      [25:0] pad
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [25:0] fit;
	always_comb begin
		fit = pulls;
		fit[9:8] = 2'h3;
		fit[5] = pulls[7];
		fit[4] = 1'h0;
	end
	// Released pins show the fitted pull (bits 9:8 high, bit 5 from bit 7, bit 4 low), never the last driven level
	assign pad = (oe & out) | (~oe & fit);
endmodule : bol_board

// ==== bol_tb.sv ====
`include "bol_map.svh"
module testbench import bol_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [25:0] s; logic [9:0] f; logic [11:0] k; logic [2:0] b;} bol_row_t;
	logic clk = 1'h0, arst_n = 1'h0, exp_write_cycle = 1'h0, debug_mode_en = 1'h1;
	logic page_512 = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [25:0] strap_address_pins_in, strap_address_pins_out, strap_address_pins_oe;
	logic [25:0] exp_addr = 26'h0, pulls = 26'h300;
	logic expansion_data_bus_oe, trace_pins_oe, tdm_clk_oe, third_mac_port_telephony;
	logic second_serial_lane_sgmii, first_serial_lane_sata, level2_cache_ctrl_sync;
	logic lane_osc_pads_sel, osc_range_select_n, osc_range_aux, crystal_mode_strap;
	logic ref_strap_bad, boot_source_bad, secure_boot_en, spi_addr_bad, spi_clk_pos;
	logic pll_en, config_valid, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	bol_boot_t boot_source_select;
	logic [19:0] uart_baud;
	logic [2:0] spi_addr_bytes;
	logic [11:0] id_block_kb, s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int err_count = 0, check_count = 0;
	bol_row_t rows [8] = '{'{26'h0000300, 10'h080, 12'h020, 3'h0},
		'{26'h0340301, 10'h380, 12'h080, 3'h2}, '{26'h00ac302, 10'h000, 12'h400, 3'h3},
		'{26'h00f3feb, 10'h0ff, 12'h800, 3'h4}, '{26'h00c0304, 10'h080, 12'h800, 3'h4},
		'{26'h0060305, 10'h080, 12'h100, 3'h2}, '{26'h0080306, 10'h080, 12'h200, 3'h3},
		'{26'h0020307, 10'h080, 12'h040, 3'h0}};
	bol_latch dut (.*);
	bol_board u_board (.pulls(pulls), .oe(strap_address_pins_oe),
		.out(strap_address_pins_out), .pad(strap_address_pins_in));
	always #12.5 clk = ~clk;
	task automatic end_sim;
		if (err_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic do_reset(input logic [25:0] s);
		pulls <= s;
		arst_n <= 1'h0;
		repeat (4) @(posedge clk);
		chk(strap_address_pins_oe, 32'h0);
		arst_n <= 1'h1;
		repeat (5) @(posedge clk);
		#1;
	endtask : do_reset
	// Both channels offered together, each released once taken
	task automatic wr(input logic [11:0] a);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'hffffffff;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin @(posedge clk iff s_axi_awready); s_axi_awvalid <= 1'h0; end
			begin @(posedge clk iff s_axi_wready); s_axi_wvalid <= 1'h0; end
		join
		@(posedge clk iff s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		@(posedge clk iff s_axi_arready);
		s_axi_arvalid <= 1'h0;
		@(posedge clk iff s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rd
	initial begin
		#(25 * 5000);
		err_count++;
		end_sim();
	end
	initial begin
		foreach (rows[i]) begin
			do_reset(rows[i].s);
			chk({pll_en, spi_clk_pos, trace_pins_oe, third_mac_port_telephony,
				second_serial_lane_sgmii, first_serial_lane_sata, level2_cache_ctrl_sync,
				osc_range_select_n, crystal_mode_strap, tdm_clk_oe}, rows[i].f);
			chk(boot_source_select, rows[i].s[2:0]);
			chk(uart_baud, rows[i].s[16] ? `BOL_BAUD_FAST : `BOL_BAUD_SLOW);
			chk(spi_addr_bytes, rows[i].b);
			chk(id_block_kb, rows[i].k);
			chk(secure_boot_en, rows[i].s[17]);
			chk({config_valid, osc_range_aux, lane_osc_pads_sel, ref_strap_bad, boot_source_bad},
				{3'h7, 1'h0, rows[i].s[2:0] == 3'h4});
			rd(12'h000);
			chk(d, {6'h0, rows[i].s});
		end
		// Last row leaves bit 14 low: data bus follows write cycles
		step();
		chk(expansion_data_bus_oe, 32'h0);
		exp_write_cycle <= 1'h1;
		exp_addr <= 26'h2aaaaaa;
		debug_mode_en <= 1'h0;
		step();
		step();
		chk(expansion_data_bus_oe, 32'h1);
		chk(strap_address_pins_out, 32'h2aaaaaa);
		chk(secure_boot_en, 32'h0);
		pulls <= 26'h3ffffff;
		wr(12'h000);
		chk(r, `BOL_RESP_OKAY);
		rd(12'h000);
		chk(d, 32'h20307);
		rd(12'h010);
		chk(r, `BOL_RESP_SLVERR);
		page_512 <= 1'h1;
		do_reset(26'h00c0302);
		chk(id_block_kb, 32'h10);
		chk(spi_addr_bad, 32'h1);
		rd(12'h004);
		chk(d, 32'h01042);
		rd(12'h008);
		chk(d, 32'h9);
		end_sim();
	end
endmodule : testbench
